// ### pkg/prog_ptr_pkg.sv
package prog_ptr_pkg;

   // Nibble addresses of the pointer inside the system register area
   localparam logic [6:0] PTR_NIB3_OFS = 7'h74;
   localparam logic [6:0] PTR_NIB2_OFS = 7'h75;
   localparam logic [6:0] PTR_NIB1_OFS = 7'h76;
   localparam logic [6:0] PTR_NIB0_OFS = 7'h77;

   localparam int NIB_W = 4;
   localparam int PTR_W = 16;
   localparam logic [15:0] PTR_RESET = 16'h0000;
   // Usable bits per variant; everything above reads and stays zero
   localparam logic [15:0] PTR_MASK_SMALL = 16'h00ff;
   localparam logic [15:0] PTR_MASK_LARGE = 16'h1fff;

   localparam int STACK_DEPTH_DEF = 8;
   localparam int SP_RESET_VAL = 7;

   typedef enum logic [2:0] {
      OP_NONE,
      OP_TABLE_READ,
      OP_INCREMENT,
      OP_PUSH,
      OP_POP,
      OP_BRANCH,
      OP_CALL
   } ptr_op_t;

   // Nibble access from the data memory path; bank is not part of it
   typedef struct packed {
      logic we;
      logic [6:0] addr;
      logic [3:0] wdata;
   } dm_req_t;

endpackage

// ### hw/stack_mem.sv
`timescale 1ns/1ps
module stack_mem #(
   parameter int WIDTH = 16,
   parameter int DEPTH = 8,
   parameter int AW = $clog2(DEPTH)
) (
   input wire logic clk_sys,              // System clock
   input wire logic wr_en,                // Write strobe
   input wire logic [AW-1:0] wr_addr,     // Write entry
   input wire logic [WIDTH-1:0] wr_data,  // Write word
   input wire logic [AW-1:0] rd_addr,     // Read entry
   output logic [WIDTH-1:0] rd_data_ff    // Registered read word
);
   logic [WIDTH-1:0] mem [DEPTH];

   always_ff @(posedge clk_sys) begin
      if (wr_en) begin
         mem[wr_addr] <= wr_data;
      end
      rd_data_ff <= mem[rd_addr];
   end
endmodule

// ### hw/prog_addr_pointer.sv
`timescale 1ns/1ps
// Behaviour
// RL1 - Pointer is 16 bits over nibbles 74H (high) to 77H (low).
// RL2 - Small variant keeps the upper 8 pointer bits at zero.
// RL3 - Large variant keeps the upper 3 pointer bits at zero.
// RL4 - Power-on, clock stop and chip-enable reset clear the pointer.
// RL5 - Table read, push, pop, indirect branch and call use the pointer.
// RL6 - Increment operation adds one to the pointer.
// RL7 - Software loads only pointer values inside program memory.
// RL8 - Table read fetches the 16-bit word at the pointer into the buffer.
// RL9 - Pointer nibbles answer at the same address in every bank.
// RL10 - Increment from the top value wraps the pointer to zero.
// RL11 - Push pre-decrements stack pointer; pop loads then post-increments.
// RL12 - Writes to fixed-zero bits are dropped; those bits read zero.
module prog_addr_pointer import prog_ptr_pkg::*; #(
   parameter bit LARGE_VARIANT = 1'b1,
   parameter int STACK_DEPTH = STACK_DEPTH_DEF,
   parameter int SP_W = $clog2(STACK_DEPTH)
) (
   input wire logic clk_sys,                 // System clock
   input wire logic rst_n,                   // Power-on reset, sync
   input wire logic clock_stop_ev,           // Clock stop instruction executed
   input wire logic ce_reset_ev,             // Chip-enable reset
   input wire dm_req_t dm_req,               // Data memory nibble access
   input wire ptr_op_t op_req,               // Pointer operation from sequencer
   input wire logic [15:0] rom_data,         // Program memory word
   output logic [3:0] rd_data_ff,            // Nibble read answer
   output logic [15:0] prog_addr_pointer_ff, // Pointer, also program address
   output logic rom_rd_ff,                   // Program memory read strobe
   output logic [15:0] transfer_buffer_ff,   // Constant word from table read
   output logic xfer_valid_ff,               // Buffer loaded pulse
   output logic jump_valid_ff,               // Indirect branch or call pulse
   output logic jump_is_call_ff,             // Jump is a subroutine call
   output logic busy_ff,                     // Multi-cycle operation running
   output logic [SP_W-1:0] stack_ptr_ff      // Address stack pointer
);
   localparam logic [15:0] PTR_MASK = LARGE_VARIANT ? PTR_MASK_LARGE : PTR_MASK_SMALL;

   typedef enum logic [1:0] {ST_IDLE, ST_TABLE, ST_POP} ptr_state_t;

   ptr_state_t state_ff, nxt_state;
   logic [15:0] nxt_ptr, nxt_buf, stack_rd;
   logic [3:0] nxt_rd;
   logic [SP_W-1:0] nxt_sp, push_addr;
   logic nxt_rom_rd, nxt_xfer, nxt_jump, nxt_call, nxt_busy, push_en;
   logic clr_evt;

   // Returns {hit, nibble index}; bank bits never reach this decode
   function automatic logic [2:0] nib_decode(input logic [6:0] addr);
      if (addr == PTR_NIB3_OFS) begin
         return 3'h7;
      end else if (addr == PTR_NIB2_OFS) begin
         return 3'h6;
      end else if (addr == PTR_NIB1_OFS) begin
         return 3'h5;
      end else if (addr == PTR_NIB0_OFS) begin
         return 3'h4;
      end else begin
         return 3'h0;
      end
   endfunction

   assign clr_evt = clock_stop_ev | ce_reset_ev;
   assign push_addr = stack_ptr_ff - SP_W'(1);
   assign push_en = (state_ff == ST_IDLE) && (op_req == OP_PUSH) && !clr_evt;

   stack_mem #(.WIDTH(PTR_W), .DEPTH(STACK_DEPTH)) u_stack (
      .clk_sys(clk_sys),
      .wr_en(push_en),                          // [RL11]
      .wr_addr(push_addr),
      .wr_data(prog_addr_pointer_ff),           // [RL5]
      .rd_addr(stack_ptr_ff),
      .rd_data_ff(stack_rd)
   );

   always_comb begin
      logic [2:0] dec;
      dec = nib_decode(dm_req.addr);
      nxt_state = state_ff;
      nxt_ptr = prog_addr_pointer_ff;
      nxt_sp = stack_ptr_ff;
      nxt_buf = transfer_buffer_ff;
      nxt_rom_rd = 1'b0;
      nxt_xfer = 1'b0;
      nxt_jump = 1'b0;
      nxt_call = 1'b0;
      // Read answer shows the masked pointer; other addresses read zero
      nxt_rd = 4'h0;
      if (dec[2]) begin
         nxt_rd = prog_addr_pointer_ff[4*dec[1:0] +: 4];              // [RL1] [RL9] [RL12]
      end
      case (state_ff)
         ST_IDLE: begin
            case (op_req)
               OP_TABLE_READ: begin
                  nxt_rom_rd = 1'b1;                                 // [RL5]
                  nxt_state = ST_TABLE;
               end
               OP_INCREMENT: begin
                  nxt_ptr = (prog_addr_pointer_ff + 16'h0001) & PTR_MASK; // [RL6] [RL10]
               end
               OP_PUSH: begin
                  nxt_sp = push_addr;                                // [RL11]
               end
               OP_POP: begin
                  nxt_state = ST_POP;
               end
               OP_BRANCH, OP_CALL: begin
                  nxt_jump = 1'b1;                                   // [RL5]
                  nxt_call = (op_req == OP_CALL);
               end
               default: begin
                  // Nibble writes are taken only when no operation runs
                  if (dm_req.we && dec[2]) begin
                     nxt_ptr[4*dec[1:0] +: 4] = dm_req.wdata;        // [RL1] [RL9]
                     nxt_ptr = nxt_ptr & PTR_MASK;                   // [RL2] [RL3] [RL12]
                  end
               end
            endcase
         end
         ST_TABLE: begin
            nxt_buf = rom_data;                                      // [RL8]
            nxt_xfer = 1'b1;
            nxt_state = ST_IDLE;
         end
         ST_POP: begin
            nxt_ptr = stack_rd & PTR_MASK;                           // [RL11]
            nxt_sp = stack_ptr_ff + SP_W'(1);                        // [RL11]
            nxt_state = ST_IDLE;
         end
         default: begin
            nxt_state = ST_IDLE;
         end
      endcase
      if (clr_evt) begin
         // Clear aborts the operation in flight; stack pointer and buffer keep their values
         nxt_ptr = PTR_RESET;                                        // [RL4]
         nxt_sp = stack_ptr_ff;
         nxt_buf = transfer_buffer_ff;
         nxt_xfer = 1'b0;
         nxt_state = ST_IDLE;
         nxt_rom_rd = 1'b0;
         nxt_jump = 1'b0;
         nxt_call = 1'b0;
      end
      nxt_busy = (nxt_state != ST_IDLE);
   end

   always_ff @(posedge clk_sys) begin
      if (!rst_n) begin
         state_ff <= ST_IDLE;
         prog_addr_pointer_ff <= PTR_RESET;                          // [RL4]
         stack_ptr_ff <= SP_W'(SP_RESET_VAL);
         transfer_buffer_ff <= 16'h0000;
         rd_data_ff <= 4'h0;
         rom_rd_ff <= 1'b0;
         xfer_valid_ff <= 1'b0;
         jump_valid_ff <= 1'b0;
         jump_is_call_ff <= 1'b0;
         busy_ff <= 1'b0;
      end else begin
         state_ff <= nxt_state;
         prog_addr_pointer_ff <= nxt_ptr;
         stack_ptr_ff <= nxt_sp;
         transfer_buffer_ff <= nxt_buf;
         rd_data_ff <= nxt_rd;
         rom_rd_ff <= nxt_rom_rd;
         xfer_valid_ff <= nxt_xfer;
         jump_valid_ff <= nxt_jump;
         jump_is_call_ff <= nxt_call;
         busy_ff <= nxt_busy;
      end
   end

   // Checks
   default clocking cb @(posedge clk_sys); endclocking
   default disable iff (!rst_n);

   logic idle_go;
   assign idle_go = (state_ff == ST_IDLE) && !clr_evt;

   chk_reset_clear: assert property (clr_evt |=> prog_addr_pointer_ff == 16'h0000) // [RL4]
      else $error("pointer not cleared by stop or chip-enable reset");
   chk_fixed_zero: assert property ((prog_addr_pointer_ff & ~PTR_MASK) == 16'h0000) // [RL2] [RL3] [RL12]
      else $error("fixed-zero pointer bits are set");
   chk_inc_wrap: assert property (idle_go && op_req == OP_INCREMENT |=>
         prog_addr_pointer_ff == (($past(prog_addr_pointer_ff) + 16'h0001) & PTR_MASK)) // [RL6] [RL10]
      else $error("increment result wrong");
   chk_table_fetch: assert property (idle_go && op_req == OP_TABLE_READ ##1 !clr_evt |->
         rom_rd_ff && busy_ff ##1 xfer_valid_ff && transfer_buffer_ff == $past(rom_data)) // [RL8]
      else $error("table read did not load the buffer");
   chk_table_addr: assert property (rom_rd_ff |-> prog_addr_pointer_ff == $past(prog_addr_pointer_ff)) // [RL5]
      else $error("pointer moved under a table read");
   chk_push_sp: assert property (idle_go && op_req == OP_PUSH |=>
         stack_ptr_ff == $past(stack_ptr_ff) - SP_W'(1)) // [RL11]
      else $error("push did not pre-decrement");
   chk_pop_order: assert property (idle_go && op_req == OP_POP ##1 !clr_evt |->
         busy_ff ##1 stack_ptr_ff == $past(stack_ptr_ff, 2) + SP_W'(1) && !busy_ff) // [RL11]
      else $error("pop did not post-increment");
   chk_jump_addr: assert property (idle_go && (op_req == OP_BRANCH || op_req == OP_CALL) |=>
         jump_valid_ff && prog_addr_pointer_ff == $past(prog_addr_pointer_ff)
         && jump_is_call_ff == ($past(op_req) == OP_CALL)) // [RL5]
      else $error("indirect jump wrong");
   chk_read_high: assert property (dm_req.addr == PTR_NIB3_OFS |=>
         rd_data_ff == $past(prog_addr_pointer_ff[15:12])) // [RL1] [RL9]
      else $error("high nibble read wrong");
   chk_write_low: assert property (idle_go && op_req == OP_NONE && dm_req.we
         && dm_req.addr == PTR_NIB0_OFS |=> prog_addr_pointer_ff[3:0] == $past(dm_req.wdata)) // [RL1]
      else $error("low nibble write lost");

   cov_table: cover property (idle_go && op_req == OP_TABLE_READ ##2 xfer_valid_ff);
   cov_wrap: cover property (idle_go && op_req == OP_INCREMENT
         && prog_addr_pointer_ff == PTR_MASK ##1 prog_addr_pointer_ff == 16'h0000);
   cov_push_pop: cover property (idle_go && op_req == OP_PUSH ##1 idle_go && op_req == OP_POP);
endmodule

// ### test/tb_top.sv
`timescale 1ns/1ps
module tb_top import prog_ptr_pkg::*; ;
   logic clk_sys;
   logic rst_n;
   logic clock_stop_ev;
   logic ce_reset_ev;
   dm_req_t dm_req;
   ptr_op_t op_req;
   logic [15:0] rom_data;
   logic [3:0] rd_data_ff;
   logic [15:0] ptr;
   logic [15:0] ptr_small;
   logic rom_rd_ff;
   logic [15:0] buf_ff;
   logic xfer_valid_ff;
   logic jump_valid_ff;
   logic jump_is_call_ff;
   logic busy_ff;
   logic [2:0] sp_ff;
   int num_errors = 0;
   int n_checks = 0;
   int cycles = 0;
   // Program memory answers a word derived from the address it is given
   assign rom_data = ptr ^ 16'ha5c3;
   prog_addr_pointer #(.LARGE_VARIANT(1'b1)) dut (.clk_sys(clk_sys), .rst_n(rst_n),
      .clock_stop_ev(clock_stop_ev), .ce_reset_ev(ce_reset_ev), .dm_req(dm_req),
      .op_req(op_req), .rom_data(rom_data), .rd_data_ff(rd_data_ff),
      .prog_addr_pointer_ff(ptr), .rom_rd_ff(rom_rd_ff), .transfer_buffer_ff(buf_ff),
      .xfer_valid_ff(xfer_valid_ff), .jump_valid_ff(jump_valid_ff),
      .jump_is_call_ff(jump_is_call_ff), .busy_ff(busy_ff), .stack_ptr_ff(sp_ff));
   prog_addr_pointer #(.LARGE_VARIANT(1'b0)) dut_small (.clk_sys(clk_sys), .rst_n(rst_n),
      .clock_stop_ev(clock_stop_ev), .ce_reset_ev(ce_reset_ev), .dm_req(dm_req),
      .op_req(op_req), .rom_data(rom_data), .rd_data_ff(), .prog_addr_pointer_ff(ptr_small),
      .rom_rd_ff(), .transfer_buffer_ff(), .xfer_valid_ff(), .jump_valid_ff(),
      .jump_is_call_ff(), .busy_ff(), .stack_ptr_ff());
   initial begin
      clk_sys = 1'b0;
      forever #2.5 clk_sys = ~clk_sys;
   end
   task automatic finish_test();
      $display("checks %0d mismatches %0d", n_checks, num_errors);
      if (num_errors == 0 && n_checks > 0) begin
         $display("NO MISMATCHES");
      end else begin
         $display("MISMATCHES SEEN");
      end
      $finish;
   endtask
   always @(posedge clk_sys) begin
      cycles++;
      if (cycles == 3000) begin
         num_errors++;
         finish_test();
      end
   end
   task automatic chk(input logic [15:0] got, input logic [15:0] exp);
      n_checks++;
      if (got !== exp) begin
         num_errors++;
         $display("wrong value at %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   task automatic wr_nib(input logic [6:0] a, input logic [3:0] d);
      @(posedge clk_sys) dm_req <= '{we: 1'b1, addr: a, wdata: d};
      @(posedge clk_sys) dm_req <= '{we: 1'b0, addr: a, wdata: 4'h0};
      #1;
   endtask
   task automatic rd_nib(input logic [6:0] a, input logic [3:0] exp);
      @(posedge clk_sys) dm_req <= '{we: 1'b0, addr: a, wdata: 4'h0};
      @(posedge clk_sys) #1;
      chk({12'h000, rd_data_ff}, {12'h000, exp});
   endtask
   task automatic do_op(input ptr_op_t op);
      @(posedge clk_sys) op_req <= op;
      @(posedge clk_sys) op_req <= OP_NONE;
      #1;
   endtask
   task automatic set_ptr(input logic [15:0] v);
      wr_nib(PTR_NIB3_OFS, v[15:12]);
      wr_nib(PTR_NIB2_OFS, v[11:8]);
      wr_nib(PTR_NIB1_OFS, v[7:4]);
      wr_nib(PTR_NIB0_OFS, v[3:0]);
   endtask
   initial begin
      rst_n = 1'b0;
      clock_stop_ev = 1'b0;
      ce_reset_ev = 1'b0;
      dm_req = '{we: 1'b0, addr: 7'h00, wdata: 4'h0};
      op_req = OP_NONE;
      repeat (8) @(posedge clk_sys);
      rst_n <= 1'b1;
      #1;
      chk(ptr, 16'h0000);
      chk({13'h0000, sp_ff}, 16'h0007);
      $display("test reset done");
      set_ptr(16'hffff);
      chk(ptr, 16'h1fff);
      chk(ptr_small, 16'h00ff);
      rd_nib(PTR_NIB3_OFS, 4'h1);
      rd_nib(PTR_NIB0_OFS, 4'hf);
      rd_nib(7'h78, 4'h0);
      wr_nib(7'h10, 4'h0);
      chk(ptr, 16'h1fff);
      do_op(OP_INCREMENT);
      chk(ptr, 16'h0000);
      chk(ptr_small, 16'h0000);
      do_op(OP_INCREMENT);
      chk(ptr, 16'h0001);
      $display("test nibbles and increment done");
      set_ptr(16'h1234);
      chk(ptr, 16'h1234);
      do_op(OP_TABLE_READ);
      chk({15'h0000, rom_rd_ff}, 16'h0001);
      chk({15'h0000, busy_ff}, 16'h0001);
      @(posedge clk_sys) #1;
      chk({15'h0000, xfer_valid_ff}, 16'h0001);
      chk(buf_ff, 16'h1234 ^ 16'ha5c3);
      $display("test table read done");
      do_op(OP_PUSH);
      chk({13'h0000, sp_ff}, 16'h0006);
      wr_nib(PTR_NIB0_OFS, 4'h0);
      chk(ptr, 16'h1230);
      do_op(OP_POP);
      chk({15'h0000, busy_ff}, 16'h0001);
      @(posedge clk_sys) #1;
      chk(ptr, 16'h1234);
      chk({13'h0000, sp_ff}, 16'h0007);
      $display("test push pop done");
      do_op(OP_BRANCH);
      chk({14'h0000, jump_valid_ff, jump_is_call_ff}, 16'h0002);
      do_op(OP_CALL);
      chk({14'h0000, jump_valid_ff, jump_is_call_ff}, 16'h0003);
      chk(ptr, 16'h1234);
      $display("test jumps done");
      @(posedge clk_sys) clock_stop_ev <= 1'b1;
      @(posedge clk_sys) clock_stop_ev <= 1'b0;
      #1;
      chk(ptr, 16'h0000);
      chk(buf_ff, 16'h1234 ^ 16'ha5c3);
      set_ptr(16'h0abc);
      @(posedge clk_sys) ce_reset_ev <= 1'b1;
      @(posedge clk_sys) ce_reset_ev <= 1'b0;
      #1;
      chk(ptr, 16'h0000);
      $display("test clears done");
      finish_test();
   end
endmodule
